// ==== hw/llcss_params.svh ====
`ifndef LLCSS_PARAMS_SVH
`define LLCSS_PARAMS_SVH
// clock rate and documented times
`define LLCSS_CLK_HZ          10000000
`define LLCSS_WAKE_US         150
`define LLCSS_BURST_MS        200
`define LLCSS_PAUSE_MS        1000
// derived cycle counts: least times round up, longest round down
`define LLCSS_WAKE_CYC  ((`LLCSS_WAKE_US * (`LLCSS_CLK_HZ / 1000) + 999) / 1000)
`define LLCSS_BURST_CYC (`LLCSS_BURST_MS * (`LLCSS_CLK_HZ / 1000))
`define LLCSS_PAUSE_CYC (`LLCSS_PAUSE_MS * (`LLCSS_CLK_HZ / 1000))
// boot charge time and sequencer timers, in cycles
`define LLCSS_BOOT_CYC        16'h0064
`define LLCSS_SEQ_WAKE_CYC    16'h0032
`define LLCSS_LS_MIN_CYC      16'h0005
`define LLCSS_LS_MAX_CYC      16'h0140
`define LLCSS_HS_MIN_CYC      16'h0005
`define LLCSS_HS_MAX_CYC      16'h0140
`define LLCSS_DT_MIN_CYC      16'h0001
`define LLCSS_DT_MAX_CYC      16'h000A
// register offsets
`define LLCSS_CTRL_OFF        8'h00
`define LLCSS_STAT_OFF        8'h04
`define LLCSS_ID_OFF          8'h08
`define LLCSS_ID_VALUE        32'h0000A5A5
// field positions
`define LLCSS_CTRL_FORCE_BIT  0
`define LLCSS_CTRL_RESET_VAL  32'h00000000
`endif

// ==== hw/llcss_pkg.sv ====
package llcss_pkg;
   typedef enum logic [3:0] {
      SUP_STARTUP, SUP_SWITCH_ON, SUP_SWITCH_OFF, SUP_WAKEUP, SUP_CHARGE_BOOT,
      SUP_NORMAL_RUN, SUP_LOW_LOAD, SUP_FAULT
   } llcss_sup_type;
   typedef enum logic [2:0] {
      SEQ_IDLE, SEQ_WAKE, SEQ_LOW_ON, SEQ_DT_LH, SEQ_HIGH_ON, SEQ_DT_HL
   } llcss_seq_type;
   // analog comparator and fault flags
   typedef struct packed {
      logic overTemperature;
      logic outputOvervoltageFault;
      logic peakOvercurrentFault;
      logic avgOvercurrentShortTimer;
      logic avgOvercurrentLongTimer;
      logic bulkAboveStart;
      logic bulkBelowStop;
      logic bulkOvervoltage;
      logic regRailUndervoltage;
      logic supplyBelowRestart;
      logic supplyAboveSwitchThreshold;
      logic feedbackBelowBurstThreshold;
   } llcss_flags_type;
   // supervisor enables
   typedef struct packed {
      logic generatorEnable;
      logic regRailEnable;
      logic softstartEnable;
      logic startupSwitchOn;
   } llcss_enables_type;
   // sequencer end-of-state conditions from the power stage
   typedef struct packed {
      logic lowDone;
      logic deadDone;
      logic highDone;
   } llcss_seqcond_type;
endpackage : llcss_pkg

// ==== hw/llcss_sequencer.sv ====
`timescale 1ns/1ps
`include "llcss_params.svh"
module llcss_sequencer (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      generatorEnable,
   input  wire logic                      outputOvervoltageFault,
   input  wire logic                      peakOvercurrentFault,
   input  wire llcss_pkg::llcss_seqcond_type cond,
   output logic                           highSideOn,
   output logic                           lowSideOn,
   output logic                           lowPower,
   output logic                           fastFault,
   output llcss_pkg::llcss_seq_type       seqState
);
   logic [15:0] tmr;
   llcss_pkg::llcss_seq_type next_seqState;
   logic        fast;
   logic        minDone;
   logic        maxDone;
   logic        done;
   logic [15:0] minCyc;
   logic [15:0] maxCyc;

   // fast faults are caught here first and force idle
   assign fast = outputOvervoltageFault | peakOvercurrentFault;

   // per-state minimum and maximum times
   always_comb begin
      minCyc = `LLCSS_DT_MIN_CYC;
      maxCyc = `LLCSS_DT_MAX_CYC;
      unique case (seqState)
         llcss_pkg::SEQ_WAKE: begin
            minCyc = `LLCSS_SEQ_WAKE_CYC;
            maxCyc = `LLCSS_SEQ_WAKE_CYC;
         end
         llcss_pkg::SEQ_LOW_ON: begin
            minCyc = `LLCSS_LS_MIN_CYC;
            maxCyc = `LLCSS_LS_MAX_CYC;
         end
         llcss_pkg::SEQ_HIGH_ON: begin
            minCyc = `LLCSS_HS_MIN_CYC;
            maxCyc = `LLCSS_HS_MAX_CYC;
         end
         llcss_pkg::SEQ_IDLE, llcss_pkg::SEQ_DT_LH, llcss_pkg::SEQ_DT_HL: begin
         end
      endcase
   end

   // a state ends on its condition once past the minimum, or at the maximum
   assign minDone = (tmr + 16'h0001) >= minCyc;
   assign maxDone = (tmr + 16'h0001) >= maxCyc;

   always_comb begin
      done = maxDone;
      unique case (seqState)
         llcss_pkg::SEQ_LOW_ON:  done = maxDone | (minDone & cond.lowDone);
         llcss_pkg::SEQ_HIGH_ON: done = maxDone | (minDone & cond.highDone);
         llcss_pkg::SEQ_DT_LH,
         llcss_pkg::SEQ_DT_HL:   done = maxDone | (minDone & cond.deadDone);
         llcss_pkg::SEQ_IDLE,
         llcss_pkg::SEQ_WAKE:    done = maxDone;
      endcase
   end

   // switching cycle: low on, dead, high on, dead
   always_comb begin
      next_seqState = seqState;
      unique case (seqState)
         llcss_pkg::SEQ_IDLE:    if (generatorEnable) next_seqState = llcss_pkg::SEQ_WAKE;
         llcss_pkg::SEQ_WAKE:    if (done) next_seqState = llcss_pkg::SEQ_LOW_ON;
         llcss_pkg::SEQ_LOW_ON:  if (done) next_seqState = llcss_pkg::SEQ_DT_LH;
         llcss_pkg::SEQ_DT_LH:   if (done) next_seqState = llcss_pkg::SEQ_HIGH_ON;
         llcss_pkg::SEQ_HIGH_ON: if (done) next_seqState = llcss_pkg::SEQ_DT_HL;
         llcss_pkg::SEQ_DT_HL:   if (done) next_seqState = llcss_pkg::SEQ_LOW_ON;
      endcase
      if (!generatorEnable || fast) begin
         next_seqState = llcss_pkg::SEQ_IDLE;
      end
   end

   // state, timer and registered outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seqState   <= llcss_pkg::SEQ_IDLE;
         tmr        <= 16'h0000;
         highSideOn <= 1'b0;
         lowSideOn  <= 1'b0;
         lowPower   <= 1'b1;
         fastFault  <= 1'b0;
      end else begin
         seqState   <= next_seqState;
         tmr        <= (next_seqState != seqState) ? 16'h0000 : tmr + 16'h0001;
         highSideOn <= next_seqState == llcss_pkg::SEQ_HIGH_ON;
         lowSideOn  <= next_seqState == llcss_pkg::SEQ_LOW_ON;
         lowPower   <= next_seqState == llcss_pkg::SEQ_IDLE;
         fastFault  <= fast & generatorEnable;
      end
   end
endmodule : llcss_sequencer

// ==== hw/llcss_top.sv ====
`timescale 1ns/1ps
`include "llcss_params.svh"
module llcss_top #(
   parameter int unsigned WAKE_CYC  = `LLCSS_WAKE_CYC,
   parameter int unsigned BURST_CYC = `LLCSS_BURST_CYC,
   parameter int unsigned PAUSE_CYC = `LLCSS_PAUSE_CYC
) (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         trimLoadDone,
   input  wire llcss_pkg::llcss_flags_type   flagsPin,
   input  wire llcss_pkg::llcss_seqcond_type condPin,
   // axi4-lite slave
   input  wire logic [7:0]                   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [7:0]                   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   // power stage
   output llcss_pkg::llcss_enables_type      enables,
   output logic                              highSideOn,
   output logic                              lowSideOn,
   output logic                              seqLowPower
);
   llcss_pkg::llcss_flags_type    flagsMeta;
   llcss_pkg::llcss_flags_type    flags;
   llcss_pkg::llcss_seqcond_type  condMeta;
   llcss_pkg::llcss_seqcond_type  cond;
   logic                          trimMeta;
   logic                          trimDone;
   llcss_pkg::llcss_sup_type      supState;
   llcss_pkg::llcss_sup_type      next_supState;
   logic [31:0]                   cnt;
   logic                          forceFault;
   logic                          fastFault;
   llcss_pkg::llcss_seq_type      seqState;
   logic                          awHeld;
   logic                          wHeld;
   logic [7:0]                    awAddr;
   logic [31:0]                   wData;

   // two-flop synchronisers for all analog flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flagsMeta <= '0;
         flags     <= '0;
         condMeta  <= '0;
         cond      <= '0;
         trimMeta  <= 1'b0;
         trimDone  <= 1'b0;
      end else begin
         flagsMeta <= flagsPin;
         flags     <= flagsMeta;
         condMeta  <= condPin;
         cond      <= condMeta;
         trimMeta  <= trimLoadDone;
         trimDone  <= trimMeta;
      end
   end

   // shared decode of supervisor conditions
   wire bulkOk   = flags.bulkAboveStart & ~flags.bulkBelowStop
                   & ~flags.bulkOvervoltage & ~flags.regRailUndervoltage;
   wire bootOk   = bulkOk & ~flags.feedbackBelowBurstThreshold;
   wire supplyOk = flags.supplyAboveSwitchThreshold & ~flags.supplyBelowRestart;
   wire runFault = flags.overTemperature | flags.bulkOvervoltage | flags.bulkBelowStop
                   | fastFault | flags.avgOvercurrentShortTimer
                   | flags.avgOvercurrentLongTimer | flags.regRailUndervoltage
                   | forceFault;
   wire earlyFault = flags.overTemperature | flags.bulkOvervoltage | forceFault;
   wire cntHit   = cnt == 32'h00000000;
   wire inRun    = (supState == llcss_pkg::SUP_NORMAL_RUN)
                   | (supState == llcss_pkg::SUP_LOW_LOAD);

   // supervisor transitions
   always_comb begin
      next_supState = supState;
      unique case (supState)
         llcss_pkg::SUP_STARTUP:
            if (trimDone) next_supState = llcss_pkg::SUP_SWITCH_ON;
         llcss_pkg::SUP_SWITCH_ON:
            if (supplyOk) next_supState = llcss_pkg::SUP_SWITCH_OFF;
         llcss_pkg::SUP_SWITCH_OFF:
            if (bulkOk) next_supState = llcss_pkg::SUP_WAKEUP;
         llcss_pkg::SUP_WAKEUP:
            if (cntHit && bootOk) next_supState = llcss_pkg::SUP_CHARGE_BOOT;
         llcss_pkg::SUP_CHARGE_BOOT:
            if (cntHit) next_supState = llcss_pkg::SUP_NORMAL_RUN;
         llcss_pkg::SUP_NORMAL_RUN:
            if (flags.feedbackBelowBurstThreshold)
               next_supState = llcss_pkg::SUP_LOW_LOAD;
         llcss_pkg::SUP_LOW_LOAD:
            if (cntHit) next_supState = llcss_pkg::SUP_FAULT;
            else if (!flags.feedbackBelowBurstThreshold)
               next_supState = llcss_pkg::SUP_NORMAL_RUN;
         llcss_pkg::SUP_FAULT:
            if (cntHit) next_supState = llcss_pkg::SUP_STARTUP;
         default: next_supState = llcss_pkg::SUP_FAULT;
      endcase
      // restart drop and fault entry override the normal path
      if (supState != llcss_pkg::SUP_FAULT && supState != llcss_pkg::SUP_STARTUP) begin
         if (inRun && runFault) next_supState = llcss_pkg::SUP_FAULT;
         else if (!inRun && earlyFault) next_supState = llcss_pkg::SUP_FAULT;
         else if (flags.supplyBelowRestart)
            next_supState = llcss_pkg::SUP_SWITCH_ON;
      end
   end

   // state timer reloads on each state entry and counts down
   function automatic logic [31:0] loadFor(input llcss_pkg::llcss_sup_type s);
      unique case (s)
         llcss_pkg::SUP_WAKEUP:      loadFor = WAKE_CYC - 1;
         llcss_pkg::SUP_CHARGE_BOOT: loadFor = 32'(`LLCSS_BOOT_CYC) - 1;
         llcss_pkg::SUP_LOW_LOAD:    loadFor = BURST_CYC - 1;
         llcss_pkg::SUP_FAULT:       loadFor = PAUSE_CYC - 1;
         default:                    loadFor = 32'h00000000;
      endcase
   endfunction : loadFor

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         supState <= llcss_pkg::SUP_STARTUP;
         cnt      <= 32'h00000000;
         enables  <= 4'h1; // startup switch on from power-up
      end else begin
         supState <= next_supState;
         if (next_supState != supState) cnt <= loadFor(next_supState);
         else if (!cntHit) cnt <= cnt - 32'h00000001;
         enables.generatorEnable <= (next_supState == llcss_pkg::SUP_NORMAL_RUN)
                                    | (next_supState == llcss_pkg::SUP_LOW_LOAD);
         enables.softstartEnable <= (next_supState == llcss_pkg::SUP_NORMAL_RUN)
                                    | (next_supState == llcss_pkg::SUP_LOW_LOAD);
         enables.startupSwitchOn <= (next_supState == llcss_pkg::SUP_STARTUP)
                                    | (next_supState == llcss_pkg::SUP_SWITCH_ON);
         enables.regRailEnable   <= !((next_supState == llcss_pkg::SUP_STARTUP)
                                    | (next_supState == llcss_pkg::SUP_SWITCH_ON)
                                    | (next_supState == llcss_pkg::SUP_FAULT));
      end
   end

   llcss_sequencer u_seq (
      .clk                    (clk),
      .rst                    (rst),
      .generatorEnable        (enables.generatorEnable),
      .outputOvervoltageFault (flags.outputOvervoltageFault),
      .peakOvercurrentFault   (flags.peakOvercurrentFault),
      .cond                   (cond),
      .highSideOn             (highSideOn),
      .lowSideOn              (lowSideOn),
      .lowPower               (seqLowPower),
      .fastFault              (fastFault),
      .seqState               (seqState)
   );

   // axi4-lite write: address and data taken in either order
   wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awHeld       <= 1'b0;
         wHeld        <= 1'b0;
         awAddr       <= 8'h00;
         wData        <= 32'h00000000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         forceFault   <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
         end
         if (doWrite) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr == `LLCSS_CTRL_OFF) ? 2'h0 : 2'h2;
            if (awAddr == `LLCSS_CTRL_OFF)
               forceFault <= wData[`LLCSS_CTRL_FORCE_BIT];
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ready only while nothing of that channel is held
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= ~awHeld & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready  <= ~wHeld & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      end
   end

   // axi4-lite read; status shows supervisor and sequencer state
   wire [31:0] statWord = {21'h000000, enables, seqState, supState};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            unique case (s_axi_araddr)
               `LLCSS_CTRL_OFF: s_axi_rdata <= {31'h00000000, forceFault};
               `LLCSS_STAT_OFF: s_axi_rdata <= statWord;
               `LLCSS_ID_OFF:   s_axi_rdata <= `LLCSS_ID_VALUE; // arbitrary value
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : llcss_top

// ==== tb/llcss_top_chk.sv ====
`timescale 1ns/1ps
module llcss_top_chk (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire llcss_pkg::llcss_flags_type   flagsPin,
   input  wire llcss_pkg::llcss_enables_type enables,
   input  wire logic                         highSideOn,
   input  wire logic                         lowSideOn,
   input  wire logic                         seqLowPower
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic       sawLow;
   logic       sawGate;
   logic [9:0] lowCnt;
   logic [4:0] deadCnt;
   // gate history, wiped whenever the sequencer parks in idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sawLow  <= 1'b0;
         sawGate <= 1'b0;
         lowCnt  <= 10'h000;
         deadCnt <= 5'h00;
      end else begin
         sawLow  <= lowSideOn | (sawLow & ~highSideOn & ~seqLowPower);
         sawGate <= (lowSideOn | highSideOn | sawGate) & ~seqLowPower;
         lowCnt  <= lowSideOn ? lowCnt + 10'h001 : 10'h000;
         deadCnt <= (sawGate & ~lowSideOn & ~highSideOn & ~seqLowPower) ? deadCnt + 5'h01 : 5'h00;
      end
   end
   // wake-up must keep both switches open
   sequence gatesOff;
      !highSideOn && !lowSideOn;
   endsequence
   sequence wakeQuiet;
      gatesOff [*8];
   endsequence
   AST_GATES_EXCLUSIVE: assert property (!(highSideOn && lowSideOn))
      else $error("both gates on");
   AST_HIGH_AFTER_LOW: assert property ($rose(highSideOn) |-> sawLow)
      else $error("high side without prior low side");
   AST_LOW_AFTER_HIGH: assert property ($rose(lowSideOn) |-> !sawLow)
      else $error("low side twice without high side");
   AST_LOW_MIN: assert property ($fell(lowSideOn) && !seqLowPower |-> lowCnt >= 10'h005)
      else $error("low side too short");
   AST_LOW_MAX: assert property (lowCnt <= 10'h140)
      else $error("low side too long");
   AST_DEAD_MAX: assert property (deadCnt <= 5'h0A)
      else $error("dead time too long");
   AST_IDLE_QUIET: assert property (seqLowPower |-> !highSideOn)
      else $error("high side on while idle");
   AST_GEN_WAKES: assert property ($rose(enables.generatorEnable) |-> ##[1:3] !seqLowPower)
      else $error("sequencer stayed idle");
   AST_WAKE_QUIET: assert property ($fell(seqLowPower) |-> wakeQuiet)
      else $error("gate on during wake-up");
   AST_FAST_FAULT: assert property (flagsPin.peakOvercurrentFault || flagsPin.outputOvervoltageFault
      |-> ##[1:5] seqLowPower)
      else $error("fast fault did not stop switching");
   AST_RUN_ENABLES: assert property (enables.generatorEnable == enables.softstartEnable)
      else $error("generator and soft start differ");
   AST_STARTUP_ENABLES: assert property (enables.startupSwitchOn
      |-> !enables.generatorEnable && !enables.regRailEnable)
      else $error("startup switch on with rail or generator");
endmodule : llcss_top_chk

// ==== tb/llcss_stage_model.sv ====
`timescale 1ns/1ps
module llcss_stage_model #(
   parameter int SETTLE = 7
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    highSideOn,
   input  wire logic                    lowSideOn,
   input  wire logic                    slow,
   output llcss_pkg::llcss_seqcond_type cond
);
   logic [1:0] gates;
   logic [7:0] held;
   // time since the gates last changed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gates <= 2'h0;
         held  <= 8'h00;
      end else begin
         gates <= {highSideOn, lowSideOn};
         held  <= ({highSideOn, lowSideOn} == gates) ? held + 8'h01 : 8'h00;
      end
   end
   // slow stage never reports, forcing the sequencer onto its max timers
   assign cond = {~slow & lowSideOn & (held >= SETTLE),
                  ~slow & ~lowSideOn & ~highSideOn & (held >= 2),
                  ~slow & highSideOn & (held >= SETTLE)};
endmodule : llcss_stage_model

// ==== tb/llcss_top_test.sv ====
`timescale 1ns/1ps
bind llcss_top llcss_top_chk u_chk (.clk(clk), .rst(rst), .flagsPin(flagsPin),
   .enables(enables), .highSideOn(highSideOn), .lowSideOn(lowSideOn), .seqLowPower(seqLowPower));
module llcss_top_test;
   logic clk, rst, trimLoadDone, slow, highSideOn, lowSideOn, seqLowPower;
   logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
   logic [7:0] awAddr, arAddr;
   logic [31:0] wData, rData, rdData;
   logic [1:0] bResp, rResp, resp;
   llcss_pkg::llcss_flags_type flags;
   llcss_pkg::llcss_seqcond_type cond;
   llcss_pkg::llcss_enables_type enables;
   int n_mismatch, cmp_count, i;
   logic [3:0] faultBits [8] = '{4'hB, 4'hA, 4'h9, 4'h8, 4'h7, 4'h5, 4'h4, 4'h3};
   llcss_top #(.WAKE_CYC(20), .BURST_CYC(50), .PAUSE_CYC(50)) dut (.clk(clk), .rst(rst),
      .trimLoadDone(trimLoadDone), .flagsPin(flags), .condPin(cond), .s_axi_awaddr(awAddr),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .enables(enables), .highSideOn(highSideOn), .lowSideOn(lowSideOn),
      .seqLowPower(seqLowPower));
   llcss_stage_model stage (.clk(clk), .rst(rst), .highSideOn(highSideOn),
      .lowSideOn(lowSideOn), .slow(slow), .cond(cond));
   // clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task final_report();
      if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   // entry edge keeps a released strobe from being raised in the same step
   task axi_write(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      awAddr <= a; wData <= d; awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (awReady) awValid <= 1'b0;
         if (wReady) wValid <= 1'b0;
         if (bValid) break;
      end
      bReady <= 1'b0;
      resp = bResp;
      if (n >= 100) begin n_mismatch++; final_report(); end
   endtask : axi_write
   task axi_read(input logic [7:0] a);
      int n;
      @(posedge clk);
      arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (arReady) arValid <= 1'b0;
         if (rValid) break;
      end
      rReady <= 1'b0;
      rdData = rData;
      resp = rResp;
      if (n >= 100) begin n_mismatch++; final_report(); end
   endtask : axi_read
   // poll the status word until the supervisor reaches a state, bounded
   task wait_sup(input logic [3:0] e);
      int n;
      for (n = 0; n < 300; n++) begin
         axi_read(8'h04);
         if (rdData[3:0] === e) break;
      end
      check("supState", {28'h0000000, e}, {28'h0000000, rdData[3:0]});
      if (rdData[3:0] !== e) final_report();
   endtask : wait_sup
   initial begin
      rst = 1'b1; trimLoadDone = 1'b0; slow = 1'b0; flags = '0;
      awAddr = 8'h00; wData = 32'h0; awValid = 1'b0; wValid = 1'b0; bReady = 1'b0;
      arAddr = 8'h00; arValid = 1'b0; rReady = 1'b0; n_mismatch = 0; cmp_count = 0;
      repeat (12) @(posedge clk);
      check("enables", 32'h1, {28'h0000000, enables});
      rst <= 1'b0;
      axi_read(8'h08);
      check("id", 32'h0000A5A5, rdData);
      axi_read(8'h10);
      check("rresp", 32'h2, {30'h0, resp});
      axi_write(8'h10, 32'h1);
      check("bresp", 32'h2, {30'h0, resp});
      axi_read(8'h00);
      check("ctrl", 32'h0, rdData);
      axi_write(8'h00, 32'h1);
      axi_read(8'h00);
      check("ctrl", 32'h1, rdData);
      axi_write(8'h00, 32'h0);
      wait_sup(4'h0);
      repeat (30) @(posedge clk);
      wait_sup(4'h0);
      trimLoadDone <= 1'b1;
      wait_sup(4'h1);
      flags.supplyAboveSwitchThreshold <= 1'b1;
      wait_sup(4'h2);
      check("enables", 32'h4, {28'h0000000, enables});
      flags.feedbackBelowBurstThreshold <= 1'b1;
      flags.bulkAboveStart <= 1'b1;
      wait_sup(4'h3);
      repeat (60) @(posedge clk);
      wait_sup(4'h3);
      flags.feedbackBelowBurstThreshold <= 1'b0;
      wait_sup(4'h5);
      check("enables", 32'hE, {28'h0000000, enables});
      slow <= 1'b1;
      repeat (1400) @(posedge clk);
      slow <= 1'b0;
      flags.feedbackBelowBurstThreshold <= 1'b1;
      wait_sup(4'h6);
      flags.feedbackBelowBurstThreshold <= 1'b0;
      wait_sup(4'h5);
      flags.feedbackBelowBurstThreshold <= 1'b1;
      wait_sup(4'h7);
      flags.feedbackBelowBurstThreshold <= 1'b0;
      wait_sup(4'h5);
      flags.supplyBelowRestart <= 1'b1;
      wait_sup(4'h1);
      check("enables", 32'h1, {28'h0000000, enables});
      // overtemperature during switch-on faults at once
      flags.overTemperature <= 1'b1;
      wait_sup(4'h7);
      flags.overTemperature <= 1'b0;
      flags.supplyBelowRestart <= 1'b0;
      wait_sup(4'h5);
      // software-forced fault through the control register
      axi_write(8'h00, 32'h1);
      wait_sup(4'h7);
      axi_write(8'h00, 32'h0);
      wait_sup(4'h5);
      // every flag-driven run fault in turn, each followed by the pause and a full restart
      for (i = 0; i < 8; i++) begin
         flags[faultBits[i]] <= 1'b1;
         wait_sup(4'h7);
         check("enables", 32'h0, {28'h0000000, enables});
         flags[faultBits[i]] <= 1'b0;
         wait_sup(4'h5);
      end
      final_report();
   end
   // hang guard
   initial begin
      repeat (50000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
endmodule : llcss_top_test
